// >>> design/mpw_pkg.sv
// Constants, types and helper functions of the ten-channel modulator.
// Assumes one core clock and an AHB-Lite register bus in front of it.
// Operation
// R1 - Frame is 2^N PWM ticks; a slot never lasts fewer than 128 ticks.
// R2 - Alternate route bit moves channels 0..7 to a second pin; 8, 9 fixed.
// R3 - Each channel waits its start delay before its first frame.
// R4 - Only the low N bits of the start delay are used.
// R5 - Usable delay is divided by the number of spreading slots.
// R6 - Synchronised channels share settings; each keeps its start delay.
// R7 - Control, data and restart registers clear on power-on reset only.
// R8 - Control bit 12 is a master enable; no output before it is set.
// R9 - Software sets master enable only after configuring all used channels.
// R10 - New duty values act only when control bit 8 loads them all.
// R11 - The duty-load bit clears itself one core clock after being set.
// R12 - Control bits 7:4 select channel 0..9; codes above 9 are reserved.
// R13 - Channel select increments after every data port read or write.
// R14 - Control bits 1:0 pick duty (00), configuration (01) or delay (1x).
// R15 - Software leaves control bits 15:13, 11:9, 3:2 alone; they read zero.
// R16 - Three registers: control, indirect data port and phase restart.
// R17 - Output high from count zero until count equals duty, then low.
// R18 - A channel runs only with local enable and master enable both set.
// R19 - Resolution code 0..8 gives 7..15 bits; 9 and above give 16 bits.
// R20 - Phase restart bits restart channels in phase, then clear next clock.
// R21 - Data port accesses with a reserved channel select are ignored.
// R22 - Delay counts PWM ticks from start or restart before the first high.
package mpw_pkg;

  localparam int          NUM_CH     = 10;
  localparam int          NUM_ALT    = 8;
  localparam int          DW         = 16;
  localparam logic [3:0]  LAST_CH    = 4'h9;

  // Register word index from HADDR[3:2]
  localparam int          ADDR_LSB   = 2;
  localparam int          ADDR_MSB   = 3;
  localparam logic [1:0]  IDX_CTRL   = 2'h0;
  localparam logic [1:0]  IDX_DATA   = 2'h1;
  localparam logic [1:0]  IDX_SYNC   = 2'h2;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  localparam int          HTRANS_ACT = 1;

  // Control register fields
  localparam int          CTL_MEN    = 12;
  localparam int          CTL_UPD    = 8;
  localparam int          CTL_SEL_HI = 7;
  localparam int          CTL_SEL_LO = 4;
  localparam int          CTL_REG_HI = 1;
  localparam int          CTL_REG_LO = 0;
  localparam logic [1:0]  REG_DUTY   = 2'h0;
  localparam logic [1:0]  REG_CFG    = 2'h1;

  // Configuration fields
  localparam int          CFG_INV    = 15;
  localparam int          CFG_ALT    = 13;
  localparam int          CFG_EN     = 12;
  localparam int          CFG_CLK_HI = 9;
  localparam int          CFG_CLK_LO = 8;
  localparam int          CFG_PS_HI  = 5;
  localparam int          CFG_PS_LO  = 4;
  localparam int          CFG_RES_HI = 3;
  localparam int          CFG_RES_LO = 0;
  localparam logic [1:0]  CLK_CORE   = 2'h0;
  localparam logic [1:0]  CLK_PERIPH = 2'h1;

  localparam logic [15:0] RST16      = 16'h0000;
  localparam logic [3:0]  RES_CODE16 = 4'h9;
  localparam logic [4:0]  RES_MIN    = 5'h07;
  localparam logic [4:0]  RES_MAX    = 5'h10;
  localparam int          SPREAD_REF = 10;

  typedef enum logic [1:0] {CH_IDLE, CH_DELAY, CH_RUN} mpw_ch_state_t;

  // Resolution bits from code
  function automatic logic [4:0] res_bits(input logic [3:0] code);
    if (code >= RES_CODE16) begin
      return RES_MAX;
    end
    return 5'({1'b0, code}) + RES_MIN;
  endfunction

  // Log2 of slot count; slots keep 2^7 ticks or more
  function automatic logic [4:0] spread_log(input logic [4:0] n,
                                            input logic [1:0] ps);
    int t;
    t = int'(n) + int'(ps) - SPREAD_REF;
    if (t < 0) begin
      return 5'h00;
    end
    return 5'(t);
  endfunction

  // Mask of the low w bits
  function automatic logic [15:0] bit_mask(input logic [4:0] w);
    return 16'((17'h0_0001 << w) - 17'h0_0001);
  endfunction

endpackage : mpw_pkg

// >>> design/mpw_channel.sv
// One modulator channel: start delay, frame counter, slot spreading.
// Assumes a one-cycle tick enable at the chosen PWM clock rate.
module mpw_channel (
  input  wire logic                   clk_in,
  input  wire logic                   rstn_in,
  input  wire logic                   tick_in,
  input  wire logic                   run_in,
  input  wire logic                   restart_in,
  input  wire logic [3:0]             res_code_in,
  input  wire logic [1:0]             spread_in,
  input  wire logic                   inv_in,
  input  wire logic [mpw_pkg::DW-1:0] duty_in,
  input  wire logic [mpw_pkg::DW-1:0] delay_in,
  output logic                        pwm_out
);
  import mpw_pkg::*;

  mpw_ch_state_t state_q;
  logic [15:0]   cnt_q, dly_cnt_q, acc_q;
  logic          extra_q;
  logic [4:0]    nbits, kbits, sbits;
  logic [15:0]   fmask, smask, slots_m1, duty_m, dly_m, pos, base;
  logic [16:0]   sum;
  logic          carry;
  logic          high;

  // ---------------------------------------------------------------
  // Frame geometry
  // ---------------------------------------------------------------
  always_comb begin
    nbits    = res_bits(res_code_in);               // R19
    kbits    = spread_log(nbits, spread_in);        // R1
    sbits    = nbits - kbits;
    fmask    = bit_mask(nbits);
    smask    = bit_mask(sbits);
    slots_m1 = bit_mask(kbits);
    duty_m   = duty_in & fmask;
    dly_m    = delay_in & smask;                    // R4 R5
    pos      = cnt_q & smask;
    base     = duty_m >> kbits;
    sum      = {1'b0, acc_q} + {1'b0, duty_m & slots_m1};
    carry    = sum > {1'b0, slots_m1};
    high     = {1'b0, pos} < ({1'b0, base} + {16'h0000, extra_q}); // R17
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q   <= CH_IDLE;
      cnt_q     <= RST16;
      dly_cnt_q <= RST16;
      acc_q     <= RST16;
      extra_q   <= 1'b0;
    end else if (!run_in) begin                     // R18
      state_q   <= CH_IDLE;
      cnt_q     <= RST16;
      dly_cnt_q <= RST16;
    end else if (restart_in) begin                  // R20 R6
      state_q   <= CH_DELAY;
      dly_cnt_q <= RST16;
    end else begin
      case (state_q)
        CH_IDLE: begin
          state_q   <= CH_DELAY;
          dly_cnt_q <= RST16;
        end
        CH_DELAY: begin                             // R3 R22
          if (dly_cnt_q >= dly_m) begin
            state_q <= CH_RUN;
            cnt_q   <= RST16;
            acc_q   <= RST16;
            extra_q <= 1'b0;
          end else if (tick_in) begin
            dly_cnt_q <= dly_cnt_q + 16'h0001;
          end
        end
        CH_RUN: begin
          if (tick_in) begin
            cnt_q <= (cnt_q + 16'h0001) & fmask;    // R1
            if (pos == smask) begin
              extra_q <= carry;
              acc_q   <= carry ? 16'(sum - {1'b0, slots_m1} - 17'h0_0001)
                               : 16'(sum);
            end
          end
        end
        default: state_q <= CH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= run_in & (inv_in ^ ((state_q == CH_RUN) & high)); // R8 R17
    end
  end

endmodule // mpw_channel

// >>> design/mpw_modulator.sv
// Top of the modulator: AHB-Lite slave, local register file, PWM clock
// enables, ten channels and output pin routing.
// Assumes RESETN_IN is the power-on reset and CLOCK_IN the core clock.
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
module mpw_modulator #(
  parameter int PERIPH_DIV = 2
) (
  input  wire logic                       CLOCK_IN,
  input  wire logic                       RESETN_IN,
  input  wire logic                       HSEL_IN,
  input  wire logic [31:0]                HADDR_IN,
  input  wire logic [1:0]                 HTRANS_IN,
  input  wire logic                       HWRITE_IN,
  input  wire logic [2:0]                 HSIZE_IN,
  input  wire logic [31:0]                HWDATA_IN,
  input  wire logic                       HREADY_IN,
  input  wire logic                       EXT_CLK_IN,
  output logic [31:0]                     HRDATA_OUT,
  output logic                            HREADYOUT_OUT,
  output logic                            HRESP_OUT,
  output logic [mpw_pkg::NUM_CH-1:0]      PRIMARY_PIN_OUT,
  output logic [mpw_pkg::NUM_ALT-1:0]     ALT_PIN_OUT
);
  import mpw_pkg::*;

  localparam logic [7:0] PER_LAST = 8'(PERIPH_DIV - 1);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic              acc_wr_q;
  logic              acc_rd_q;
  logic [1:0]        acc_idx_q;
  logic              take;
  logic              wr_fire;
  logic              rd_fire;
  logic              data_acc;
  logic              sel_ok;

  logic              master_en_q;
  logic              duty_load_q;
  logic [3:0]        chan_sel_q;
  logic [1:0]        reg_sel_q;
  logic [NUM_CH-1:0] restart_q;

  logic [DW-1:0]     duty_value_q     [NUM_CH];
  logic [DW-1:0]     duty_active_q    [NUM_CH];
  logic [DW-1:0]     channel_config_q [NUM_CH];
  logic [DW-1:0]     start_delay_q    [NUM_CH];

  logic [DW-1:0]     ctrl_view;
  logic [DW-1:0]     data_view;
  logic [31:0]       read_value;

  logic [7:0]        per_cnt_q;
  logic              per_tick_q;
  logic              ext_s1_q;
  logic              ext_s2_q;
  logic              ext_s3_q;
  logic              ext_lvl_q;
  logic              ext_tick_q;

  logic [NUM_CH-1:0] pwm_w;

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  assign take    = HSEL_IN & HTRANS_IN[HTRANS_ACT] & HREADY_IN
                   & (HSIZE_IN == HSIZE_WORD);
  assign wr_fire = acc_wr_q & HREADY_IN;
  assign rd_fire = acc_rd_q & ~HREADYOUT_OUT;
  assign data_acc = (wr_fire | rd_fire) & (acc_idx_q == IDX_DATA);
  assign sel_ok  = chan_sel_q <= LAST_CH;

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      acc_wr_q  <= 1'b0;
      acc_rd_q  <= 1'b0;
      acc_idx_q <= IDX_CTRL;
    end else if (HREADY_IN) begin
      acc_wr_q  <= take & HWRITE_IN;
      acc_rd_q  <= take & ~HWRITE_IN;
      acc_idx_q <= HADDR_IN[ADDR_MSB:ADDR_LSB];
    end
  end

  // Reads take one wait state
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      HREADYOUT_OUT <= 1'b1;
      HRDATA_OUT    <= 32'h0000_0000;
    end else if (rd_fire) begin
      HREADYOUT_OUT <= 1'b1;
      HRDATA_OUT    <= read_value;
    end else if (take & ~HWRITE_IN) begin
      HREADYOUT_OUT <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      HRESP_OUT <= 1'b0;
    end else begin
      HRESP_OUT <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_view                        = RST16;       // R15
    ctrl_view[CTL_MEN]               = master_en_q;
    ctrl_view[CTL_UPD]               = duty_load_q;
    ctrl_view[CTL_SEL_HI:CTL_SEL_LO] = chan_sel_q;
    ctrl_view[CTL_REG_HI:CTL_REG_LO] = reg_sel_q;
    data_view                        = RST16;
    if (sel_ok) begin                               // R21
      case (reg_sel_q)                              // R14
        REG_DUTY: data_view = duty_value_q[chan_sel_q];
        REG_CFG:  data_view = channel_config_q[chan_sel_q];
        default:  data_view = start_delay_q[chan_sel_q];
      endcase
    end
    case (acc_idx_q)                                // R16
      IDX_CTRL: read_value = {16'h0000, ctrl_view};
      IDX_DATA: read_value = {16'h0000, data_view};
      IDX_SYNC: read_value = {22'h00_0000, restart_q};
      default:  read_value = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin                           // R7
      master_en_q <= 1'b0;
      reg_sel_q   <= REG_DUTY;
    end else if (wr_fire && acc_idx_q == IDX_CTRL) begin
      master_en_q <= HWDATA_IN[CTL_MEN];            // R8
      reg_sel_q   <= HWDATA_IN[CTL_REG_HI:CTL_REG_LO];
    end
  end

  // Write wins over self clear
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      duty_load_q <= 1'b0;
    end else if (wr_fire && acc_idx_q == IDX_CTRL) begin
      duty_load_q <= HWDATA_IN[CTL_UPD];
    end else begin
      duty_load_q <= 1'b0;                          // R11
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      chan_sel_q <= 4'h0;
    end else if (wr_fire && acc_idx_q == IDX_CTRL) begin
      chan_sel_q <= HWDATA_IN[CTL_SEL_HI:CTL_SEL_LO]; // R12
    end else if (data_acc) begin                    // R13
      chan_sel_q <= (chan_sel_q == LAST_CH) ? 4'h0 : chan_sel_q + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Phase restart register
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      restart_q <= '0;
    end else if (wr_fire && acc_idx_q == IDX_SYNC) begin
      restart_q <= HWDATA_IN[NUM_CH-1:0];           // R20
    end else begin
      restart_q <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Local register file
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_value_q[i]     <= RST16;
        channel_config_q[i] <= RST16;
        start_delay_q[i]    <= RST16;
      end
    end else if (wr_fire && acc_idx_q == IDX_DATA && sel_ok) begin // R21
      case (reg_sel_q)                              // R14
        REG_DUTY: duty_value_q[chan_sel_q]     <= HWDATA_IN[DW-1:0];
        REG_CFG:  channel_config_q[chan_sel_q] <= HWDATA_IN[DW-1:0];
        default:  start_delay_q[chan_sel_q]    <= HWDATA_IN[DW-1:0];
      endcase
    end
  end

  // Duty copies load together
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_active_q[i] <= RST16;
      end
    end else if (duty_load_q) begin                 // R10
      for (int i = 0; i < NUM_CH; i++) begin
        duty_active_q[i] <= duty_value_q[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // PWM clock enables
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      per_cnt_q  <= 8'h00;
      per_tick_q <= 1'b0;
    end else begin
      per_cnt_q  <= (per_cnt_q == PER_LAST) ? 8'h00 : per_cnt_q + 8'h01;
      per_tick_q <= per_cnt_q == PER_LAST;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= EXT_CLK_IN;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // Rising edge counts once stages 2, 3 agree high
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ext_lvl_q  <= 1'b0;
      ext_tick_q <= 1'b0;
    end else begin
      ext_tick_q <= (ext_s2_q == ext_s3_q) & ext_s2_q & ~ext_lvl_q;
      if (ext_s2_q == ext_s3_q) begin
        ext_lvl_q <= ext_s2_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Channels and pin routing
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic [DW-1:0] cfg;
    logic          tick;

    assign cfg = channel_config_q[g];

    always_comb begin
      case (cfg[CFG_CLK_HI:CFG_CLK_LO])
        CLK_CORE:   tick = 1'b1;
        CLK_PERIPH: tick = per_tick_q;
        default:    tick = ext_tick_q;
      endcase
    end

    mpw_channel u_ch (
      .clk_in      (CLOCK_IN),
      .rstn_in     (RESETN_IN),
      .tick_in     (tick),
      .run_in      (cfg[CFG_EN] & master_en_q),    // R18 R8
      .restart_in  (restart_q[g]),
      .res_code_in (cfg[CFG_RES_HI:CFG_RES_LO]),
      .spread_in   (cfg[CFG_PS_HI:CFG_PS_LO]),
      .inv_in      (cfg[CFG_INV]),
      .duty_in     (duty_active_q[g]),
      .delay_in    (start_delay_q[g]),
      .pwm_out     (pwm_w[g])
    );
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      PRIMARY_PIN_OUT <= '0;
      ALT_PIN_OUT     <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin        // R2
        if (i < NUM_ALT) begin
          PRIMARY_PIN_OUT[i] <= pwm_w[i] & ~channel_config_q[i][CFG_ALT];
          ALT_PIN_OUT[i]     <= pwm_w[i] & channel_config_q[i][CFG_ALT];
        end else begin
          PRIMARY_PIN_OUT[i] <= pwm_w[i];
        end
      end
    end
  end

endmodule // mpw_modulator

// >>> testbench/mpw_load_model.sv
// Load model on the modulator pins: high-cycle counts and last rise of each primary pin.
// Assumes pins settle on the core clock; clr_in zeroes the counts.
module mpw_load_model (
  input  wire logic       clk_in,
  input  wire logic       clr_in,
  input  wire logic [9:0] prim_in,
  input  wire logic [7:0] alt_in,
  output int              p_cnt_out[10],
  output int              a_cnt_out[8],
  output int              rise_out[10]
);
  timeunit 1ns;
  timeprecision 100ps;
  int         cyc;
  logic [9:0] prev;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    prev <= prim_in;
    for (int i = 0; i < 10; i++) begin
      if (prim_in[i] && !prev[i]) begin
        rise_out[i] <= cyc;
      end
      p_cnt_out[i] <= clr_in ? 0 : p_cnt_out[i] + int'(prim_in[i]);
    end
    for (int i = 0; i < 8; i++) begin
      a_cnt_out[i] <= clr_in ? 0 : a_cnt_out[i] + int'(alt_in[i]);
    end
  end
endmodule // mpw_load_model

// >>> testbench/mpw_modulator_asserts.sv
// Checker of bus answers, read data and pins of the modulator.
// Assumes one AHB-Lite master and HREADY_IN tied to HREADYOUT_OUT.
module mpw_modulator_asserts #(
  parameter int PERIPH_DIV = 2
) (
  input wire logic                        CLOCK_IN,
  input wire logic                        RESETN_IN,
  input wire logic                        HSEL_IN,
  input wire logic [31:0]                 HADDR_IN,
  input wire logic [1:0]                  HTRANS_IN,
  input wire logic                        HWRITE_IN,
  input wire logic [2:0]                  HSIZE_IN,
  input wire logic                        HREADY_IN,
  input wire logic [31:0]                 HRDATA_OUT,
  input wire logic                        HREADYOUT_OUT,
  input wire logic                        HRESP_OUT,
  input wire logic [mpw_pkg::NUM_CH-1:0]  PRIMARY_PIN_OUT,
  input wire logic [mpw_pkg::NUM_ALT-1:0] ALT_PIN_OUT
);
  import mpw_pkg::*;
  // ----
  // Read tracking
  // ----
  logic       take;
  logic       rd_q;
  logic [1:0] idx_q;
  logic       done;
  assign take = HSEL_IN & HTRANS_IN[1] & HREADY_IN
              & (HSIZE_IN == HSIZE_WORD);
  assign done = rd_q & HREADYOUT_OUT;
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rd_q <= 1'b0;
      idx_q <= 2'h0;
    end else if (take && !HWRITE_IN) begin
      rd_q <= 1'b1;
      idx_q <= HADDR_IN[ADDR_MSB:ADDR_LSB];
    end else if (HREADYOUT_OUT) begin
      rd_q <= 1'b0;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);
  chk_resp_okay: assert property (HRESP_OUT == 1'b0)
    else $error("response not OKAY");
  chk_read_wait: assert property (take && !HWRITE_IN |=>
    !HREADYOUT_OUT ##1 HREADYOUT_OUT) else $error("read wait wrong");
  chk_write_nowait: assert property (take && HWRITE_IN |=>
    HREADYOUT_OUT) else $error("write stalled");
  chk_pin_single: assert property (
    (PRIMARY_PIN_OUT[NUM_ALT-1:0] & ALT_PIN_OUT) == '0)
    else $error("channel on both pins");
  chk_rdata_hold: assert property (!rd_q |=> $stable(HRDATA_OUT))
    else $error("read data moved");
  chk_rdata_upper: assert property (done |->
    HRDATA_OUT[31:16] == 16'h0000) else $error("upper read bits set");
  chk_ctrl_resv: assert property (done && idx_q == IDX_CTRL |->
    HRDATA_OUT[15:13] == 3'h0 && HRDATA_OUT[11:9] == 3'h0
    && HRDATA_OUT[3:2] == 2'h0) else $error("control reserved set");
  chk_restart_resv: assert property (done && idx_q == IDX_SYNC |->
    HRDATA_OUT[15:10] == 6'h00) else $error("restart reserved set");
  chk_unmapped_zero: assert property (done && idx_q == 2'h3 |->
    HRDATA_OUT == 32'h0000_0000) else $error("unmapped read set");
  chk_reset_idle: assert property ($rose(RESETN_IN) |->
    (PRIMARY_PIN_OUT == '0 && ALT_PIN_OUT == '0) [*3])
    else $error("pins active after reset");
  cov_ctrl_read: cover property (done && idx_q == IDX_CTRL);
  cov_alt_pin: cover property (ALT_PIN_OUT != '0);
  cov_last_ch: cover property (PRIMARY_PIN_OUT[NUM_CH-1]);
endmodule // mpw_modulator_asserts

bind mpw_modulator mpw_modulator_asserts #(.PERIPH_DIV(PERIPH_DIV)) u_chk (
  .CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN), .HSEL_IN(HSEL_IN),
  .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
  .HSIZE_IN(HSIZE_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
  .PRIMARY_PIN_OUT(PRIMARY_PIN_OUT), .ALT_PIN_OUT(ALT_PIN_OUT)
);

// >>> testbench/mpw_modulator_tb_top.sv
// Self-checking bench of the ten-channel modulator.
// Assumes the load model and checker are compiled first.
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, e); \
  end \
end
module mpw_modulator_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mpw_pkg::*;
  localparam logic [31:0] A_CTL = 32'h0000_0000, A_DAT = 32'h0000_0004,
    A_SYN = 32'h0000_0008, A_BAD = 32'h0000_000C;
  logic              clk, rst_n, hsel, hwrite, ext_clk, clr, hready, hresp;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       haddr, hwdata, hrdata;
  logic [NUM_CH-1:0] prim;
  logic [NUM_ALT-1:0] alt;
  int                error_cnt, compares;
  int                p_cnt[NUM_CH], a_cnt[NUM_ALT], rise_t[NUM_CH];
  logic [31:0]       exp_q[$];
  logic [15:0]       mem[3][NUM_CH];
  logic [15:0] t_cfg[NUM_CH] = '{16'h1000, 16'h3000, 16'h1101, 16'h1200,
    16'h9000, 16'h1000, 16'h1000, 16'h0000, 16'h1000, 16'h1001};
  logic [15:0] t_duty[NUM_CH] = '{16'h0020, 16'h0064, 16'h00C8, 16'h0040,
    16'h0020, 16'h0040, 16'h0040, 16'h0040, 16'h007F, 16'h00FF};
  int ep[NUM_CH] = '{256, 0, 800, 512, 768, 512, 512, 0, 1016, 1020};

  mpw_modulator #(.PERIPH_DIV(2)) dut (
    .CLOCK_IN(clk), .RESETN_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .EXT_CLK_IN(ext_clk),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .PRIMARY_PIN_OUT(prim), .ALT_PIN_OUT(alt));
  mpw_load_model u_load (.clk_in(clk), .clr_in(clr), .prim_in(prim),
    .alt_in(alt), .p_cnt_out(p_cnt), .a_cnt_out(a_cnt), .rise_out(rise_t));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // External PWM clock, 16 ns period
  initial begin
    ext_clk = 1'b0;
    #1;
    forever #8 ext_clk = ~ext_clk;
  end
  // ----
  // Bus master and monitor
  // ----
  task automatic xfer(input logic wr, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask
  task automatic wr(input logic [31:0] a, d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0000_0000);
  endtask
  initial begin : monitor
    logic        pend;
    logic [31:0] e;
    pend = 1'b0;
    forever begin
      @(posedge clk);
      if (pend && hready === 1'b1) begin
        e = exp_q.pop_front();
        `CHK(hrdata, e)
        pend = 1'b0;
      end
      if (hsel && htrans[1] && !hwrite && hready === 1'b1) pend = 1'b1;
    end
  end
  task automatic setch(input int ch, input logic [15:0] dl);
    logic [31:0] s;
    s = 32'(ch) << 4;
    wr(A_CTL, s);
    wr(A_DAT, {16'h0000, t_duty[ch]});
    wr(A_CTL, s | 32'h0000_0001);
    wr(A_DAT, {16'h0000, t_cfg[ch]});
    wr(A_CTL, s | 32'h0000_0002);
    wr(A_DAT, {16'h0000, dl});
  endtask
  task automatic measure(input int n, input bit on);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
    for (int i = 0; i < NUM_CH; i++) begin
      `CHK(p_cnt[i], on ? ep[i] : 0)
    end
    for (int i = 0; i < NUM_ALT; i++) begin
      `CHK(a_cnt[i], (on && i == 1) ? 800 : 0)
    end
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog, far past the run
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
  // ----
  // Tests
  // ----
  initial begin
    int d;
    {hsel, hwrite, clr, rst_n, htrans, haddr, hwdata} = '0;
    hsize = HSIZE_WORD;
    {error_cnt, compares} = '0;
    void'($urandom(32'h078c944c));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_CTL, 32'h0000_0000);
    rd(A_SYN, 32'h0000_0000);
    wr(A_BAD, 32'h0000_FFFF);
    rd(A_BAD, 32'h0000_0000);
    rd(A_DAT, 32'h0000_0000);
    rd(A_CTL, 32'h0000_0010);
    note("reset values");
    for (int r = 0; r < 3; r++) begin
      wr(A_CTL, 32'(r));
      for (int c = 0; c < NUM_CH; c++) begin
        mem[r][c] = 16'($urandom) & ((r == 1) ? 16'hB33F : 16'hFFFF);
        wr(A_DAT, {16'h0000, mem[r][c]});
      end
    end
    for (int r = 0; r < 4; r++) begin
      if (r == 2) continue;
      wr(A_CTL, 32'(r));
      for (int c = 0; c < NUM_CH; c++) begin
        rd(A_DAT, {16'h0000, mem[(r > 1) ? 2 : r][c]});
      end
    end
    rd(A_CTL, 32'h0000_0003);
    note("local registers");
    wr(A_CTL, 32'h0000_00F0);
    wr(A_DAT, 32'h0000_5555);
    rd(A_CTL, 32'h0000_0000);
    wr(A_CTL, 32'h0000_00A0);
    wr(A_DAT, 32'h0000_1234);
    rd(A_DAT, 32'h0000_0000);
    rd(A_CTL, 32'h0000_00C0);
    wr(A_CTL, 32'h0000_0000);
    rd(A_DAT, {16'h0000, mem[0][0]});
    note("reserved select");
    for (int c = 0; c < NUM_CH; c++) begin
      setch(c, (c == 6) ? 16'h0F0A : 16'h0000);
    end
    wr(A_CTL, 32'h0000_0100);
    measure(300, 1'b0);
    wr(A_CTL, 32'h0000_1100);
    rd(A_CTL, 32'h0000_1000);
    repeat (200) @(posedge clk);
    measure(1024, 1'b1);
    wr(A_CTL, 32'h0000_1000);
    wr(A_DAT, 32'h0000_0040);
    measure(1024, 1'b1);
    wr(A_CTL, 32'h0000_1100);
    ep[0] = 512;
    repeat (200) @(posedge clk);
    measure(1024, 1'b1);
    note("pwm output");
    wr(A_SYN, 32'h0000_0020);
    repeat (50) @(posedge clk);
    wr(A_SYN, 32'h0000_0060);
    rd(A_SYN, 32'h0000_0000);
    repeat (400) @(posedge clk);
    d = rise_t[6] - rise_t[5];
    `CHK(((d % 128) + 128) % 128, 10)
    note("phase restart");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_CTL, 32'h0000_0000);
    rd(A_DAT, 32'h0000_0000);
    measure(300, 1'b0);
    note("second reset");
    report_and_stop();
  end
endmodule // mpw_modulator_tb_top
